/* hw/ocg_pkg.sv */
package ocg_pkg;

  // Register map, one aligned word each
  localparam logic [7:0] OFS_SCC      = 8'h00;
  localparam logic [7:0] OFS_FAST_RC_OSC_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_CRYSTAL_OSC_CONTROL     = 8'h08;
  localparam logic [7:0] OFS_POWER_CONTROL     = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_CLR  = 8'h14;
  localparam logic [7:0] OFS_INT_EN   = 8'h18;

  // system_clock_control fields
  localparam int SCC_SEL_LSB       = 5;
  localparam int SCC_SRC_BIT       = 3;
  localparam int SCC_FAST_KEEP_BIT = 1;
  localparam int SCC_SLOW_KEEP_BIT = 0;
  localparam logic [7:0] SCC_MASK  = 8'heb;
  localparam logic [7:0] SCC_RST   = 8'h00;
  localparam logic [2:0] SEL_SLOW  = 3'h7;

  // Oscillator control fields, same layout for both fast oscillators
  localparam int OSC_FLAG_BIT    = 1;
  localparam int OSC_EN_BIT      = 0;
  localparam logic INTERNAL_FAST_RC_OSC_EN_RST   = 1'b1;
  localparam logic HXT_EN_RST    = 1'b0;

  // power_control fields
  localparam int PWR_PORTA_WAKE  = 7;
  localparam int PWR_TB_WAKE     = 4;
  localparam int PWR_POR         = 3;
  localparam int PWR_LOWCUR      = 2;
  localparam int PWR_ISO         = 1;
  localparam int PWR_DEEP        = 0;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h9f;
  localparam logic [7:0] POWER_CONTROL_RST  = 8'h08;

  // Interrupt events
  localparam int EV_HALT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_FRC  = 2;
  localparam int EV_XTAL = 3;
  localparam int EV_W    = 4;

  // Oscillator settling time
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 4000;
  localparam logic [15:0] SETTLE_CYCLES =
    16'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    PM_RUN, PM_SLEEP, PM_IDLE_LOW, PM_IDLE_DUAL, PM_IDLE_HIGH, PM_DEEP
  } ocg_pm_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ocg_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ocg_apb_rsp_s;

  typedef struct packed {
    logic       coreClkEn;
    logic       coreTick;
    logic       fastClkEn;
    logic       fastRcOn;
    logic       crystalOn;
    logic       slowClkEn;
    logic       slowRcOn;
    logic       regulatorOn;
    logic       sysSlow;
    logic [2:0] sysDivSel;
    logic       timeBaseSlowRc;
    logic       ioIsolate;
    logic       regLowCurrent;
  } ocg_clk_s;

  typedef struct packed {
    logic [7:0]  system_clock_control;
    logic        fast_rc_enable;
    logic        hircFlag;
    logic [15:0] hircCnt;
    logic        crystal_enable;
    logic        hxtFlag;
    logic [15:0] hxtCnt;
    logic [7:0]  power_control;
    logic [EV_W-1:0] intStat;
    logic [EV_W-1:0] intEn;
    ocg_pm_e     pm;
    logic [2:0]  haltSel;
    logic        haltSrc;
    logic [5:0]  divCnt;
    logic [31:0] prdata;
  } ocg_state_s;

endpackage

/* hw/ocg_clock_ctrl.sv */
// Added by the designer: the APB interface to the registers and the address map.
module ocg_clock_ctrl
  import ocg_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire ocg_pkg::ocg_apb_req_s apbReq,
  output ocg_pkg::ocg_apb_rsp_s      apbRsp,
  input  wire logic                  haltReq,
  input  wire logic                  portAWake,
  input  wire logic                  timeBaseWake,
  input  wire logic                  otherWake,
  input  wire logic                  wdtEnable,
  input  wire logic                  slowTick,
  output ocg_pkg::ocg_clk_s          clkCtl,
  output logic                       irq
);
  import ocg_pkg::*;

  ocg_state_s s_q;
  ocg_state_s s_d;
  logic       running;
  logic [2:0] selEff;
  logic       srcEff;
  logic       slowSel;
  logic       selOscEn;
  logic       divTick;
  logic       wakeAny;
  logic       wrAcc;
  logic       rdSetup;
  logic       mapped;
  logic [EV_W-1:0] ev;

  function automatic ocg_pm_e decodeHalt(input logic deep, input logic fk, input logic sk);
    ocg_pm_e m;
    if (deep)
      m = PM_DEEP;
    else if (fk && sk)
      m = PM_IDLE_DUAL;
    else if (fk)
      m = PM_IDLE_HIGH;
    else if (sk)
      m = PM_IDLE_LOW;
    else
      m = PM_SLEEP;
    return m;
  endfunction

  function automatic logic [5:0] divMask(input logic [2:0] sel);
    return 6'((7'h01 << sel) - 7'h01);
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return a == OFS_SCC || a == OFS_FAST_RC_OSC_CONTROL || a == OFS_CRYSTAL_OSC_CONTROL || a == OFS_POWER_CONTROL ||
           a == OFS_INT_STAT || a == OFS_INT_CLR || a == OFS_INT_EN;
  endfunction

  // While halted the sampled selection governs, not the live register
  assign running  = s_q.pm == PM_RUN;
  assign selEff   = running ? s_q.system_clock_control[SCC_SEL_LSB +: 3] : s_q.haltSel;
  assign srcEff   = running ? s_q.system_clock_control[SCC_SRC_BIT] : s_q.haltSrc;
  assign slowSel  = selEff == SEL_SLOW;
  assign selOscEn = srcEff ? s_q.crystal_enable : s_q.fast_rc_enable;
  assign divTick  = (s_q.divCnt & divMask(selEff)) == divMask(selEff);
  assign wakeAny  = portAWake | timeBaseWake | otherWake;
  assign wrAcc    = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdSetup  = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign mapped   = isMapped(apbReq.paddr);

  always_comb
  begin
    s_d = s_q;
    ev  = '0;
    s_d.divCnt = 6'(s_q.divCnt + 6'h01);

    // Read data captured in setup so it comes from flops in access
    if (rdSetup)
    begin
      s_d.prdata = '0;
      case (apbReq.paddr)
        OFS_SCC:      s_d.prdata[7:0] = s_q.system_clock_control;
        OFS_FAST_RC_OSC_CONTROL:
        begin
          s_d.prdata[OSC_FLAG_BIT] = s_q.hircFlag;
          s_d.prdata[OSC_EN_BIT]   = s_q.fast_rc_enable;
        end
        OFS_CRYSTAL_OSC_CONTROL:
        begin
          s_d.prdata[OSC_FLAG_BIT] = s_q.hxtFlag;
          s_d.prdata[OSC_EN_BIT]   = s_q.crystal_enable;
        end
        OFS_POWER_CONTROL:     s_d.prdata[7:0] = s_q.power_control;
        OFS_INT_STAT: s_d.prdata[EV_W-1:0] = s_q.intStat;
        OFS_INT_EN:   s_d.prdata[EV_W-1:0] = s_q.intEn;
        default:      s_d.prdata = '0;
      endcase
    end

    if (wrAcc)
    begin
      case (apbReq.paddr)
        OFS_SCC:    s_d.system_clock_control = apbReq.pwdata[7:0] & SCC_MASK;
        OFS_FAST_RC_OSC_CONTROL:
        begin
          s_d.fast_rc_enable = apbReq.pwdata[OSC_EN_BIT];
          if (apbReq.pwdata[OSC_EN_BIT] && !s_q.fast_rc_enable)
          begin
            s_d.hircFlag = 1'b0;
            s_d.hircCnt  = '0;
          end
        end
        OFS_CRYSTAL_OSC_CONTROL:
        begin
          s_d.crystal_enable = apbReq.pwdata[OSC_EN_BIT];
          if (apbReq.pwdata[OSC_EN_BIT] && !s_q.crystal_enable)
          begin
            s_d.hxtFlag = 1'b0;
            s_d.hxtCnt  = '0;
          end
        end
        OFS_POWER_CONTROL:   s_d.power_control = apbReq.pwdata[7:0] & POWER_CONTROL_MASK;
        OFS_INT_CLR: s_d.intStat = s_q.intStat & ~apbReq.pwdata[EV_W-1:0];
        OFS_INT_EN: s_d.intEn = apbReq.pwdata[EV_W-1:0];
        default:    s_d.intEn = s_q.intEn;
      endcase
    end

    // Settle counters; a disabled oscillator is never stable
    if (!s_d.fast_rc_enable)
      s_d.hircFlag = 1'b0;
    else if (s_q.fast_rc_enable && !s_q.hircFlag)
    begin
      s_d.hircCnt = 16'(s_q.hircCnt + 16'h0001);
      if (s_q.hircCnt == SETTLE_CYCLES - 16'h0001)
      begin
        s_d.hircFlag = 1'b1;
        ev[EV_FRC]   = 1'b1;
      end
    end
    if (!s_d.crystal_enable)
      s_d.hxtFlag = 1'b0;
    else if (s_q.crystal_enable && !s_q.hxtFlag)
    begin
      s_d.hxtCnt = 16'(s_q.hxtCnt + 16'h0001);
      if (s_q.hxtCnt == SETTLE_CYCLES - 16'h0001)
      begin
        s_d.hxtFlag = 1'b1;
        ev[EV_XTAL] = 1'b1;
      end
    end

    case (s_q.pm)
      PM_RUN:
      begin
        if (haltReq)
        begin
          s_d.pm = decodeHalt(s_q.power_control[PWR_DEEP], s_q.system_clock_control[SCC_FAST_KEEP_BIT],
                              s_q.system_clock_control[SCC_SLOW_KEEP_BIT]);
          s_d.haltSel = s_q.system_clock_control[SCC_SEL_LSB +: 3];
          s_d.haltSrc = s_q.system_clock_control[SCC_SRC_BIT];
          ev[EV_HALT] = 1'b1;
        end
      end
      PM_SLEEP, PM_IDLE_LOW, PM_IDLE_DUAL, PM_IDLE_HIGH, PM_DEEP:
      begin
        if (wakeAny)
        begin
          s_d.pm = PM_RUN;
          ev[EV_WAKE] = 1'b1;
          // Wake source flags only mark exits from deep sleep; set beats a write
          if (s_q.pm == PM_DEEP && portAWake)
            s_d.power_control[PWR_PORTA_WAKE] = 1'b1;
          if (s_q.pm == PM_DEEP && timeBaseWake)
            s_d.power_control[PWR_TB_WAKE] = 1'b1;
        end
      end
      default: s_d.pm = PM_RUN;
    endcase

    // Set wins over a clear in the same cycle
    s_d.intStat = s_d.intStat | ev;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.system_clock_control      <= SCC_RST;
      s_q.fast_rc_enable   <= INTERNAL_FAST_RC_OSC_EN_RST;
      s_q.crystal_enable    <= HXT_EN_RST;
      s_q.power_control     <= POWER_CONTROL_RST;
      s_q.pm       <= PM_RUN;
    end
    else
      s_q <= s_d;
  end

  assign apbRsp.prdata  = s_q.prdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~mapped;

  always_comb
  begin
    clkCtl = '0;
    clkCtl.coreClkEn   = running;
    clkCtl.sysSlow     = slowSel;
    clkCtl.sysDivSel   = selEff;
    // Divided tick from the fast clock, slow strobe in slow run
    clkCtl.coreTick    = running & (slowSel ? slowTick : divTick);
    // Normal run needs the fast clock; slow run leaves it to the enable bit
    clkCtl.fastClkEn   = running ? (slowSel ? selOscEn : 1'b1)
                       : (s_q.pm == PM_IDLE_DUAL || s_q.pm == PM_IDLE_HIGH);
    clkCtl.fastRcOn    = clkCtl.fastClkEn & ~srcEff;
    clkCtl.crystalOn   = clkCtl.fastClkEn & srcEff;
    clkCtl.slowClkEn   = running | s_q.pm == PM_IDLE_LOW | s_q.pm == PM_IDLE_DUAL;
    clkCtl.slowRcOn    = clkCtl.slowClkEn | s_q.pm == PM_IDLE_HIGH | wdtEnable;
    clkCtl.regulatorOn = s_q.pm != PM_DEEP;
    clkCtl.timeBaseSlowRc = (s_q.pm == PM_DEEP) & wdtEnable;
    clkCtl.ioIsolate   = s_q.power_control[PWR_ISO];
    clkCtl.regLowCurrent = s_q.power_control[PWR_LOWCUR];
  end

  assign irq = |(s_q.intStat & s_q.intEn);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_normalRun;
    running && !slowSel |-> clkCtl.fastClkEn && clkCtl.coreClkEn && !clkCtl.sysSlow;
  endproperty
  a_normalRun: assert property (p_normalRun) else $error("normal run lost fast clock");

  property p_srcSel;
    clkCtl.fastClkEn |-> clkCtl.crystalOn == srcEff && clkCtl.fastRcOn == !srcEff;
  endproperty
  a_srcSel: assert property (p_srcSel) else $error("wrong fast source");

  property p_slowRun;
    running && slowSel |-> clkCtl.sysSlow && clkCtl.slowClkEn
      && clkCtl.fastClkEn == selOscEn && clkCtl.coreTick == slowTick;
  endproperty
  a_slowRun: assert property (p_slowRun) else $error("slow run clocks wrong");

  property p_regRun;
    running |-> clkCtl.regulatorOn && clkCtl.slowRcOn;
  endproperty
  a_regRun: assert property (p_regRun) else $error("regulator off while running");

  property p_sleep;
    running && haltReq && !s_q.power_control[PWR_DEEP] && s_q.system_clock_control[1:0] == 2'b00
      |=> s_q.pm == PM_SLEEP && !clkCtl.coreClkEn && !clkCtl.fastClkEn
      && !clkCtl.slowClkEn && clkCtl.slowRcOn == wdtEnable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_idleLow;
    running && haltReq && !s_q.power_control[PWR_DEEP] && s_q.system_clock_control[1:0] == 2'b01
      |=> !clkCtl.coreClkEn && clkCtl.slowClkEn && !clkCtl.fastClkEn;
  endproperty
  a_idleLow: assert property (p_idleLow) else $error("low idle clocks wrong");

  property p_idleDual;
    running && haltReq && !s_q.power_control[PWR_DEEP] && s_q.system_clock_control[1:0] == 2'b11
      |=> !clkCtl.coreClkEn && clkCtl.slowClkEn && clkCtl.fastClkEn;
  endproperty
  a_idleDual: assert property (p_idleDual) else $error("dual idle clocks wrong");

  property p_idleHigh;
    running && haltReq && !s_q.power_control[PWR_DEEP] && s_q.system_clock_control[1:0] == 2'b10
      |=> !clkCtl.coreClkEn && !clkCtl.slowClkEn && clkCtl.fastClkEn;
  endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("high idle clocks wrong");

  property p_deep;
    running && haltReq && s_q.power_control[PWR_DEEP] |=> s_q.pm == PM_DEEP
      && !clkCtl.regulatorOn && !clkCtl.coreClkEn && !clkCtl.fastClkEn && !clkCtl.slowClkEn;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep entry wrong");

  property p_deepTb;
    s_q.pm == PM_DEEP |-> clkCtl.timeBaseSlowRc == wdtEnable && clkCtl.slowRcOn == wdtEnable;
  endproperty
  a_deepTb: assert property (p_deepTb) else $error("deep sleep time base wrong");

  property p_lircKeep;
    !running && wdtEnable |-> clkCtl.slowRcOn;
  endproperty
  a_lircKeep: assert property (p_lircKeep) else $error("slow RC stopped with watchdog");

  property p_settle;
    $rose(s_q.fast_rc_enable) |-> !s_q.hircFlag ##1 (!s_q.hircFlag || !s_q.fast_rc_enable) [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("stable flag not cleared");

  property p_sample;
    running && haltReq |=> s_q.haltSel == $past(s_q.system_clock_control[7:5])
      && s_q.haltSrc == $past(s_q.system_clock_control[3]);
  endproperty
  a_sample: assert property (p_sample) else $error("halt sample wrong");

  c_deep:   cover property (s_q.pm == PM_DEEP ##[1:20] s_q.pm == PM_RUN);
  c_idle:   cover property (s_q.pm == PM_IDLE_DUAL);
  c_stable: cover property ($rose(s_q.hxtFlag));
  c_irq:    cover property ($rose(irq));

endmodule

/* dv/ocg_core_model.sv */
module ocg_core_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [1:0] lag,
  output logic            haltReq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  // Halt strobe after a chosen lag, so prompt and late cores are both seen
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 3'h0;
      haltReq <= 1'b0;
    end
    else
    begin
      haltReq <= (cnt_q == 3'h1);
      if (go)
        cnt_q <= {1'b0, lag} + 3'h1;
      else if (cnt_q != 3'h0)
        cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule

/* dv/tb_operating_mode_clock_gating.sv */
module tb_operating_mode_clock_gating;
  import ocg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock, rst, haltReq, go, pAW, tbW, oW, wdt, slowTick, irq, se;
  logic [1:0]   lag;
  logic [31:0]  rd;
  ocg_apb_req_s req;
  ocg_apb_rsp_s rsp;
  ocg_clk_s     ck;
  int           errTotal, compares, n, g, sel, k, deep, sc, cyc;

  ocg_clock_ctrl DUT (.clock(clock), .rst(rst), .apbReq(req), .apbRsp(rsp),
    .haltReq(haltReq), .portAWake(pAW), .timeBaseWake(tbW), .otherWake(oW),
    .wdtEnable(wdt), .slowTick(slowTick), .clkCtl(ck), .irq(irq));
  ocg_core_model core (.clock(clock), .rst(rst), .go(go), .lag(lag), .haltReq(haltReq));

  always #5 clock = ~clock;

  task give_verdict();
    $display("errors %0d compares %0d", errTotal, compares);
    if (errTotal == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    compares++;
    if (s !== e)
    begin
      errTotal++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask

  task tmo(input bit c);
    if (c)
    begin
      errTotal++;
      give_verdict();
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    tmo(n == 20);
    rd = rsp.prdata;
    se = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task halt();
    @(posedge clock);
    go <= 1'b1;
    lag <= 2'($urandom);
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    while (ck.coreClkEn !== 1'b0 && n < 10)
    begin
      @(negedge clock);
      n++;
    end
    tmo(n == 10);
  endtask

  task wake(input int s);
    @(posedge clock);
    oW <= (s == 0);
    pAW <= (s == 1);
    tbW <= (s == 2);
    @(posedge clock);
    {oW, pAW, tbW} <= 3'h0;
    @(negedge clock);
    chk(ck.coreClkEn, 1, "woken");
  endtask

  task gap(output int gg);
    n = 0;
    while (ck.coreTick !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    gg = 0;
    do
    begin
      @(negedge clock);
      gg++;
    end
    while (ck.coreTick !== 1'b1 && gg < 200);
    tmo(n == 200 || gg == 200);
  endtask

  // Hang guard well inside the cycle budget
  always @(posedge clock)
  begin
    cyc++;
    slowTick <= ($urandom % 8) == 0;
    tmo(cyc > 90000);
  end

  initial
  begin
    {clock, go, lag, pAW, tbW, oW, wdt, slowTick} = '0;
    rst = 1'b1;
    req = '0;
    {errTotal, compares, cyc} = '0;
    void'($urandom(32'h38f49090));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    apb(0, OFS_SCC, 0);
    chk(rd, 0, "scc");
    apb(0, OFS_FAST_RC_OSC_CONTROL, 0);
    chk(rd, 1, "frc");
    apb(0, OFS_POWER_CONTROL, 0);
    chk(rd, 8, "power_control");
    apb(0, 8'h1c, 0);
    chk({31'h0, se}, 1, "unmapped err");
    chk(rd, 0, "unmapped data");
    apb(1, OFS_INT_EN, 32'hf);
    apb(1, OFS_CRYSTAL_OSC_CONTROL, 1);
    apb(0, OFS_CRYSTAL_OSC_CONTROL, 0);
    chk(rd, 1, "xtal");
    repeat (SETTLE_CYCLES + 4) @(posedge clock);
    apb(0, OFS_CRYSTAL_OSC_CONTROL, 0);
    chk(rd, 3, "xtal");
    apb(0, OFS_FAST_RC_OSC_CONTROL, 0);
    chk(rd, 3, "frc");
    apb(0, OFS_INT_STAT, 0);
    chk(rd, 32'hc, "stat");
    chk(irq, 1, "irq");
    for (sel = 0; sel < 8; sel++)
    begin
      apb(1, OFS_SCC, (sel << 5) | 8);
      @(negedge clock);
      chk(ck.sysDivSel, sel, "sel");
      chk(ck.sysSlow, sel == 7, "slow");
      chk(ck.regulatorOn, 1, "reg");
      chk({ck.crystalOn, ck.fastRcOn}, 2, "src");
      if (sel < 7)
      begin
        gap(g);
        chk(g, 1 << sel, "div");
      end
    end
    // Crystal off in slow run must gate the fast clock
    apb(1, OFS_CRYSTAL_OSC_CONTROL, 0);
    @(negedge clock);
    chk(ck.fastClkEn, 0, "fast");
    apb(1, OFS_CRYSTAL_OSC_CONTROL, 1);
    @(negedge clock);
    chk(ck.fastClkEn, 1, "fast");
    // Re-enable the fast RC so its flag restarts alongside the crystal
    apb(1, OFS_FAST_RC_OSC_CONTROL, 0);
    apb(1, OFS_FAST_RC_OSC_CONTROL, 1);
    apb(0, OFS_FAST_RC_OSC_CONTROL, 0);
    chk(rd, 1, "frc restart");
    repeat (SETTLE_CYCLES + 4) @(posedge clock);
    apb(0, OFS_FAST_RC_OSC_CONTROL, 0);
    chk(rd, 3, "frc settled");
    apb(1, OFS_INT_CLR, 32'hf);
    apb(0, OFS_INT_CLR, 0);
    chk(rd, 0, "clr");
    chk(irq, 0, "irq");
    for (k = 0; k < 16; k++)
    begin
      deep = (k / 4) % 2;
      sc = (($urandom % 8) << 5) | (k % 4) | 8;
      @(posedge clock);
      wdt <= (k >= 8);
      apb(1, OFS_INT_EN, (k == 15) ? 0 : 15);
      apb(1, OFS_SCC, sc);
      apb(1, OFS_POWER_CONTROL, deep);
      halt();
      @(negedge clock);
      chk(ck.regulatorOn, !deep, "reg");
      chk(ck.fastClkEn, !deep && k[1], "fast");
      chk(ck.slowClkEn, !deep && k[0], "slow");
      chk(ck.slowRcOn, wdt || (!deep && k % 4 != 0), "lrc");
      chk(ck.timeBaseSlowRc, deep && wdt, "tb");
      chk(irq, k != 15, "irq");
      apb(1, OFS_SCC, sc ^ 32'he3);
      @(negedge clock);
      chk(ck.fastClkEn, !deep && k[1], "held");
      chk(ck.sysDivSel, (sc >> 5) & 7, "held");
      wake(k % 3);
      chk(ck.slowClkEn, 1, "run");
      apb(0, OFS_POWER_CONTROL, 0);
      chk(rd, deep | ((deep && k % 3 == 1) << 7) | ((deep && k % 3 == 2) << 4), "wflag");
      apb(0, OFS_INT_STAT, 0);
      chk(rd & 3, 3, "stat");
      apb(1, OFS_INT_CLR, 32'hf);
      @(negedge clock);
      chk(irq, 0, "irq");
    end
    give_verdict();
  end
endmodule
